// ---- src/dosc_main.sv ----
// dosc_main: operating-state controller of the main phase loop
// assumes detector and selector inputs arrive asynchronously from pins;
// the loop filter itself lives outside and obeys the control outputs
//
// What this block does
// RL1: six states: three primary, three temporary
// RL2: automatic control after every reset
// RL3: forced mode lets outside command transitions
// RL4: free-run follows local oscillator, no reference
// RL5: calibration word applied to generated frequency
// RL6: reference selected moves free-run to prelock
// RL7: prelock locks within 100 s else free-run
// RL8: automatic mode enters locked only after one second continuous lock
// RL9: locked state tracks selected reference
// RL10: phase loss enters lost-phase, keeps trying
// RL11: in lost-phase, leaky bucket serious disqualifies the reference
// RL12: lost-phase over 100 s disqualifies, alarms unless leaky bucket serious in that same cycle
// RL13: disqualified: standby gives prelock2, else holdover
// RL14: invalid reference, no replacement: enter holdover
// RL15: holdover freezes frequency at entry value
// RL16: state reported as 3-bit status field
// RL17: secondary loop: two automatic states only
// RL18: holdover to prelock2 on selection or revertive
// RL19: prelock2 locks within 100 s else holdover
// RL20: each state has a distinct fixed code
`timescale 1ns/1ps
module dosc_main
   import dosc_pkg::*;
#(
   parameter longint unsigned LOCK_QUAL_CYCLES = dosc_pkg::LOCK_QUAL_CYC,
   parameter longint unsigned ACQ_LIMIT_CYCLES = dosc_pkg::ACQ_LIMIT_CYC,
   parameter int unsigned FREQ_W = 19
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic force_mode_in,
   input wire logic force_req_in,
   input wire logic [dosc_pkg::STATE_FIELD_W-1:0] force_state_in,
   input wire logic ref_selected_in,
   input wire logic ref_valid_in,
   input wire logic phase_lock_in,
   input wire logic phase_loss_in,
   input wire logic bucket_serious_in,
   input wire logic standby_good_in,
   input wire logic revert_restore_in,
   input wire logic sec_ref_selected_in,
   input wire logic sec_lock_in,
   input wire logic [15:0] nom_freq_in,
   input wire logic [FREQ_W-1:0] loop_freq_in,
   output logic [dosc_pkg::STATE_FIELD_W-1:0] main_loop_state_field_out,
   output logic track_ref_out,
   output logic use_local_osc_out,
   output logic freeze_freq_out,
   output logic [FREQ_W-1:0] held_freq_out,
   output logic [15:0] nom_freq_out,
   output logic disqualify_out,
   output logic phase_alarm_out,
   output logic reselect_out,
   output logic sec_locked_out,
   output logic sec_zero_offset_out
);
   import dosc_pkg::*;

   // refuse counts the timers cannot serve, before anything runs
   if (LOCK_QUAL_CYCLES < 1 || ACQ_LIMIT_CYCLES < 2 || FREQ_W < 1 ||
       LOCK_QUAL_CYCLES >= 64'h8000_0000_0000_0000 ||
       ACQ_LIMIT_CYCLES >= 64'h8000_0000_0000_0000) begin : g_bad_param
      $error("dosc_main: unsupported parameter values");
   end

   // ***********************************************************************
   // input synchronisers
   // ***********************************************************************
   localparam int unsigned NSYNC = 11;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] syn;
   logic f_mode, f_req, r_sel, r_valid, p_lock, p_loss, bucket, standby;
   logic revert, s_sel, s_lock;

   assign raw = {force_mode_in, force_req_in, ref_selected_in, ref_valid_in,
                 phase_lock_in, phase_loss_in, bucket_serious_in,
                 standby_good_in, revert_restore_in, sec_ref_selected_in,
                 sec_lock_in};
   assign {f_mode, f_req, r_sel, r_valid, p_lock, p_loss, bucket, standby,
           revert, s_sel, s_lock} = syn;

   dosc_sync #(.WIDTH(NSYNC)) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .async_in(raw),
      .sync_out(syn)
   );

   // forced target and calibration word are quasi-static configuration,
   // so they are double-registered as buses; change them only while stable
   logic [2:0] fst1, fst2;
   logic [15:0] nf1, nf2;
   logic [FREQ_W-1:0] lf1, lf2;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         fst1 <= '0;
         fst2 <= '0;
         nf1 <= NOM_FREQ_RESET;
         nf2 <= NOM_FREQ_RESET;
         lf1 <= '0;
         lf2 <= '0;
      end else begin
         fst1 <= force_state_in;
         fst2 <= fst1;
         nf1 <= nom_freq_in;
         nf2 <= nf1;
         lf1 <= loop_freq_in;
         lf2 <= lf1;
      end
   end

   // ***********************************************************************
   // secondary loop
   // ***********************************************************************
   logic sec_locked_w, sec_zero_w;
   dosc_sec_loop u_sec (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ref_selected_in(s_sel),
      .lock_ok_in(s_lock),
      .locked_out(sec_locked_w),
      .zero_offset_out(sec_zero_w)
   );

   // ***********************************************************************
   // main state machine
   // ***********************************************************************
   dosc_state_e state, next_state; // see RL1
   logic [63:0] lock_cnt, next_lock_cnt;   // continuous-lock timer
   logic [63:0] dwell_cnt, next_dwell_cnt; // time in temporary state
   logic [FREQ_W-1:0] held, next_held;
   logic disq, next_disq, alarm, next_alarm, resel, next_resel;
   logic lock_qualified, dwell_expired;

   assign lock_qualified = (lock_cnt >= LOCK_QUAL_CYCLES - 64'd1) & p_lock;
   assign dwell_expired = dwell_cnt >= ACQ_LIMIT_CYCLES - 64'd1;

   // map a forced code onto a state; unknown codes are ignored
   function automatic logic decode_code(input logic [2:0] c,
                                        output dosc_state_e s);
      begin
         s = DOSC_FREE_RUN;
         decode_code = 1'b1;
         case (c)
            CODE_FREE_RUN: s = DOSC_FREE_RUN;
            CODE_HOLDOVER: s = DOSC_HOLDOVER;
            CODE_LOCKED: s = DOSC_LOCKED;
            CODE_PRELOCK: s = DOSC_PRELOCK;
            CODE_SECOND_PRELOCK: s = DOSC_SECOND_PRELOCK;
            CODE_LOST_PHASE: s = DOSC_LOST_PHASE;
            default: decode_code = 1'b0;
         endcase
      end
   endfunction : decode_code

   // next-state logic; automatic unless force mode is set
   always_comb begin
      dosc_state_e fs;
      logic fok;
      fs = DOSC_FREE_RUN;
      fok = decode_code(fst2, fs);
      next_state = state;
      next_disq = 1'b0;
      next_alarm = 1'b0;
      next_resel = 1'b0;
      next_held = held;
      if (f_mode) begin
         if (f_req && fok) begin
            next_state = fs; // see RL3
         end
      end else begin
         case (state) // see RL2
            DOSC_FREE_RUN: begin
               if (r_sel) begin
                  next_state = DOSC_PRELOCK; // see RL6
               end
            end
            DOSC_PRELOCK: begin
               if (r_sel && lock_qualified) begin
                  next_state = DOSC_LOCKED; // see RL8
               end else if (dwell_expired) begin
                  next_state = DOSC_FREE_RUN; // see RL7
                  next_resel = 1'b1;
               end
            end
            DOSC_SECOND_PRELOCK: begin
               if (r_sel && lock_qualified) begin
                  next_state = DOSC_LOCKED; // see RL8
               end else if (dwell_expired) begin
                  next_state = DOSC_HOLDOVER; // see RL19
                  next_resel = 1'b1;
               end
            end
            DOSC_LOCKED: begin
               if (!r_valid && !standby) begin
                  next_state = DOSC_HOLDOVER; // see RL14
               end else if (p_loss) begin
                  next_state = DOSC_LOST_PHASE; // see RL10
               end
            end
            DOSC_LOST_PHASE: begin
               if (bucket || dwell_expired || !r_valid) begin
                  next_disq = 1'b1; // see RL11
                  next_alarm = dwell_expired & ~bucket; // see RL12
                  next_state = standby ? DOSC_SECOND_PRELOCK
                                       : DOSC_HOLDOVER; // see RL13
               end else if (r_sel && lock_qualified) begin
                  next_state = DOSC_LOCKED; // see RL8
               end
            end
            DOSC_HOLDOVER: begin
               if ((r_sel && r_valid) || revert) begin
                  next_state = DOSC_SECOND_PRELOCK; // see RL18
               end
            end
            default: next_state = DOSC_FREE_RUN;
         endcase
      end
      // freeze on the very cycle holdover is entered
      if (next_state == DOSC_HOLDOVER && state != DOSC_HOLDOVER) begin
         next_held = lf2; // see RL15
      end
      // lock timer counts uninterrupted lock only
      if (!p_lock || p_loss) begin
         next_lock_cnt = '0;
      end else if (lock_cnt < LOCK_QUAL_CYCLES - 64'd1) begin
         next_lock_cnt = lock_cnt + 64'd1;
      end else begin
         next_lock_cnt = lock_cnt;
      end
      // dwell timer restarts on every state change
      if (next_state != state) begin
         next_dwell_cnt = '0;
      end else if (!dwell_expired) begin
         next_dwell_cnt = dwell_cnt + 64'd1;
      end else begin
         next_dwell_cnt = dwell_cnt;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= DOSC_FREE_RUN;
         lock_cnt <= '0;
         dwell_cnt <= '0;
         held <= '0;
         disq <= 1'b0;
         alarm <= 1'b0;
         resel <= 1'b0;
      end else begin
         state <= next_state;
         lock_cnt <= next_lock_cnt;
         dwell_cnt <= next_dwell_cnt;
         held <= next_held;
         disq <= next_disq;
         alarm <= next_alarm;
         resel <= next_resel;
      end
   end

   // ***********************************************************************
   // registered outputs
   // ***********************************************************************
   logic [2:0] code;
   always_comb begin
      case (state) // see RL20
         DOSC_FREE_RUN: code = CODE_FREE_RUN;
         DOSC_HOLDOVER: code = CODE_HOLDOVER;
         DOSC_LOCKED: code = CODE_LOCKED;
         DOSC_PRELOCK: code = CODE_PRELOCK;
         DOSC_SECOND_PRELOCK: code = CODE_SECOND_PRELOCK;
         DOSC_LOST_PHASE: code = CODE_LOST_PHASE;
         default: code = CODE_FREE_RUN;
      endcase
   end

   // outputs lag the state register by one cycle, all from flops
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         main_loop_state_field_out <= CODE_FREE_RUN;
         track_ref_out <= 1'b0;
         use_local_osc_out <= 1'b1;
         freeze_freq_out <= 1'b0;
         held_freq_out <= '0;
         nom_freq_out <= NOM_FREQ_RESET;
         disqualify_out <= 1'b0;
         phase_alarm_out <= 1'b0;
         reselect_out <= 1'b0;
         sec_locked_out <= 1'b0;
         sec_zero_offset_out <= 1'b1;
      end else begin
         main_loop_state_field_out <= code; // see RL16
         track_ref_out <= (state == DOSC_LOCKED); // see RL9
         use_local_osc_out <= (state == DOSC_FREE_RUN); // see RL4
         freeze_freq_out <= (state == DOSC_HOLDOVER); // see RL15
         held_freq_out <= held;
         nom_freq_out <= nf2; // see RL5
         disqualify_out <= disq;
         phase_alarm_out <= alarm; // see RL12
         reselect_out <= resel;
         sec_locked_out <= sec_locked_w; // see RL17
         sec_zero_offset_out <= sec_zero_w;
      end
   end
endmodule : dosc_main

// ---- src/dosc_pkg.sv ----
// dosc_pkg: shared constants and types of the loop operating-state control
// assumes a single 125 MHz system clock domain
package dosc_pkg;

   // ***********************************************************************
   // timing
   // ***********************************************************************
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned LOCK_QUAL_S = 1;     // continuous lock for entry
   localparam int unsigned ACQ_LIMIT_S = 100;   // prelock / lost-phase limit
   localparam longint unsigned LOCK_QUAL_CYC = 64'(LOCK_QUAL_S) * CLK_HZ;
   localparam longint unsigned ACQ_LIMIT_CYC = 64'(ACQ_LIMIT_S) * CLK_HZ;

   // ***********************************************************************
   // calibration word and state codes
   // ***********************************************************************
   localparam logic [15:0] NOM_FREQ_RESET = 16'h9999; // zero ppm offset
   localparam logic [7:0] NOM_FREQ_HI_IDX = 8'h3c;
   localparam logic [7:0] NOM_FREQ_LO_IDX = 8'h3d;
   localparam logic [7:0] STATE_REG_IDX = 8'h09;
   localparam int unsigned STATE_FIELD_LSB = 0;
   localparam int unsigned STATE_FIELD_W = 3;

   typedef enum logic [2:0] {
      DOSC_FREE_RUN,
      DOSC_HOLDOVER,
      DOSC_LOCKED,
      DOSC_PRELOCK,
      DOSC_SECOND_PRELOCK,
      DOSC_LOST_PHASE
   } dosc_state_e;

   // fixed status codes for the state field
   localparam logic [2:0] CODE_FREE_RUN = 3'h1;
   localparam logic [2:0] CODE_HOLDOVER = 3'h2;
   localparam logic [2:0] CODE_LOCKED = 3'h4;
   localparam logic [2:0] CODE_PRELOCK = 3'h5;
   localparam logic [2:0] CODE_SECOND_PRELOCK = 3'h6;
   localparam logic [2:0] CODE_LOST_PHASE = 3'h7;

endpackage : dosc_pkg

// ---- src/dosc_sync.sv ----
// dosc_sync: two-flop synchroniser for a vector of independent levels
// assumes every bit is a slow level from outside the clock domain
`timescale 1ns/1ps
module dosc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // first stage is read only by the second
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end
   assign sync_out = stage2;
endmodule : dosc_sync

// ---- src/dosc_sec_loop.sv ----
// dosc_sec_loop: two-state automatic control of the secondary loop
// assumes lock indication already synchronised to clk_sys_in
`timescale 1ns/1ps
module dosc_sec_loop (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ref_selected_in,
   input wire logic lock_ok_in,
   output logic locked_out,
   output logic zero_offset_out
);
   logic locked;
   logic next_locked;

   // starts in holdover with zero offset; no free-run, no forcing
   always_comb begin
      next_locked = ref_selected_in & lock_ok_in; // see RL17
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         locked <= 1'b0;
      end else begin
         locked <= next_locked;
      end
   end

   assign locked_out = locked;
   assign zero_offset_out = ~locked;
endmodule : dosc_sec_loop

// ---- sim/dosc_main_asserts.sv ----
// dosc_main_asserts: port-level checks of the main loop state control
// assumes binding to dosc_main, one clock domain, async high reset
`timescale 1ns/1ps
module dosc_main_asserts
   import dosc_pkg::*;
#(
   parameter int unsigned FREQ_W = 19
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic force_mode_in,
   input wire logic phase_loss_in,
   input wire logic bucket_serious_in,
   input wire logic ref_valid_in,
   input wire logic [15:0] nom_freq_in,
   input wire logic [dosc_pkg::STATE_FIELD_W-1:0] main_loop_state_field_out,
   input wire logic track_ref_out,
   input wire logic use_local_osc_out,
   input wire logic freeze_freq_out,
   input wire logic [FREQ_W-1:0] held_freq_out,
   input wire logic [15:0] nom_freq_out,
   input wire logic disqualify_out,
   input wire logic phase_alarm_out,
   input wire logic sec_locked_out,
   input wire logic sec_zero_offset_out
);
   // ********
   // properties
   // ********
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // locked with a steady loss and a usable reference, no force
   sequence s_loss;
      main_loop_state_field_out == CODE_LOCKED && !force_mode_in &&
      phase_loss_in ##1 (phase_loss_in && !force_mode_in &&
      !bucket_serious_in && ref_valid_in) [*2];
   endsequence
   property p_code; main_loop_state_field_out != 3'h0 &&
      main_loop_state_field_out != 3'h3; endproperty
   property p_osc; use_local_osc_out ==
      (main_loop_state_field_out == CODE_FREE_RUN); endproperty
   property p_track; track_ref_out ==
      (main_loop_state_field_out == CODE_LOCKED); endproperty
   property p_freeze; freeze_freq_out ==
      (main_loop_state_field_out == CODE_HOLDOVER); endproperty
   property p_held; freeze_freq_out && $past(freeze_freq_out) |->
      $stable(held_freq_out); endproperty
   property p_alarm; phase_alarm_out |-> disqualify_out; endproperty
   property p_pulse; disqualify_out |=> !disqualify_out; endproperty
   property p_loss; s_loss |->
      ##[0:4] main_loop_state_field_out == CODE_LOST_PHASE; endproperty
   property p_sec; sec_locked_out |-> !sec_zero_offset_out; endproperty
   property p_rst; $fell(rst_in) |->
      main_loop_state_field_out == CODE_FREE_RUN; endproperty
   // the word passes three flops, so four steady samples are ample
   property p_nom; $stable(nom_freq_in) [*4] |->
      nom_freq_out == nom_freq_in; endproperty
   a_code: assert property (p_code)
      else $error("state field holds an unused code");
   a_osc: assert property (p_osc)
      else $error("local oscillator flag disagrees with state");
   a_track: assert property (p_track)
      else $error("tracking flag disagrees with state");
   a_freeze: assert property (p_freeze)
      else $error("freeze flag disagrees with state");
   a_held: assert property (p_held)
      else $error("held frequency moved in holdover");
   a_alarm: assert property (p_alarm)
      else $error("phase alarm without disqualification");
   a_pulse: assert property (p_pulse)
      else $error("disqualify pulse longer than one cycle");
   a_loss: assert property (p_loss)
      else $error("phase loss did not reach lost phase");
   a_sec: assert property (p_sec)
      else $error("secondary loop in both states");
   a_rst: assert property (p_rst)
      else $error("reset did not leave free run");
   a_nom: assert property (p_nom)
      else $error("calibration word not passed on");
endmodule : dosc_main_asserts

// ---- sim/dosc_ref_model.sv ----
// dosc_ref_model: reference selector and detectors on the far side
// assumes level commands from the bench, same clock as the block
`timescale 1ns/1ps
module dosc_ref_model (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic sel_cmd_in,
   input wire logic lock_cmd_in,
   input wire logic loss_cmd_in,
   output logic ref_selected_out,
   output logic ref_valid_out,
   output logic phase_lock_out,
   output logic phase_loss_out
);
   // levels move on the rising edge, as a card's registered outputs do
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ref_selected_out <= 1'h0;
         ref_valid_out <= 1'h0;
         phase_lock_out <= 1'h0;
         phase_loss_out <= 1'h0;
      end else begin
         ref_selected_out <= sel_cmd_in;
         ref_valid_out <= sel_cmd_in;
         // no lock is shown without a reference or during a loss
         phase_lock_out <= sel_cmd_in & lock_cmd_in & ~loss_cmd_in;
         phase_loss_out <= loss_cmd_in;
      end
   end
endmodule : dosc_ref_model

// ---- sim/dosc_main_tb.sv ----
// dosc_main_tb: directed scenarios for the main loop state control
// assumes dosc_ref_model on the detector side and a 125 MHz clock
`timescale 1ns/1ps
module dosc_main_tb;
   import dosc_pkg::*;
   // short counts keep the run brief; expectations derive from these
   localparam int LQ = 20;
   localparam int ACQ = 100;
   localparam logic [2:0] CODES [6] = '{CODE_FREE_RUN, CODE_HOLDOVER,
      CODE_LOCKED, CODE_PRELOCK, CODE_SECOND_PRELOCK, CODE_LOST_PHASE};
   logic clk_sys_in, rst_in, force_mode_in, force_req_in;
   logic [2:0] force_state_in, main_loop_state_field_out;
   logic ref_selected_in, ref_valid_in, phase_lock_in, phase_loss_in;
   logic bucket_serious_in, standby_good_in, revert_restore_in;
   logic sec_ref_selected_in, sec_lock_in, sel_cmd, lock_cmd, loss_cmd;
   logic [15:0] nom_freq_in, nom_freq_out;
   logic [18:0] loop_freq_in, held_freq_out;
   logic track_ref_out, use_local_osc_out, freeze_freq_out, disqualify_out;
   logic phase_alarm_out, reselect_out, sec_locked_out, sec_zero_offset_out;
   int error_cnt = 0;
   int compares = 0;
   int disq_n = 0;
   int alarm_n = 0;
   int resel_n = 0;
   int n;
   // ********
   // structure
   // ********
   dosc_main #(.LOCK_QUAL_CYCLES(LQ), .ACQ_LIMIT_CYCLES(ACQ)) dut (
      .clk_sys_in, .rst_in, .force_mode_in, .force_req_in, .force_state_in,
      .ref_selected_in, .ref_valid_in, .phase_lock_in, .phase_loss_in,
      .bucket_serious_in, .standby_good_in, .revert_restore_in,
      .sec_ref_selected_in, .sec_lock_in, .nom_freq_in, .loop_freq_in,
      .main_loop_state_field_out, .track_ref_out, .use_local_osc_out,
      .freeze_freq_out, .held_freq_out, .nom_freq_out, .disqualify_out,
      .phase_alarm_out, .reselect_out, .sec_locked_out,
      .sec_zero_offset_out);
   dosc_ref_model u_ref (.clk_sys_in, .rst_in, .sel_cmd_in(sel_cmd),
      .lock_cmd_in(lock_cmd), .loss_cmd_in(loss_cmd),
      .ref_selected_out(ref_selected_in), .ref_valid_out(ref_valid_in),
      .phase_lock_out(phase_lock_in), .phase_loss_out(phase_loss_in));
   initial begin
      clk_sys_in = 1'h0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // pulses last one cycle, so each rise is tallied; counting on the
   // pulse itself avoids a race with checks made at the falling edge
   always @(posedge disqualify_out) disq_n++;
   always @(posedge phase_alarm_out) alarm_n++;
   always @(posedge reselect_out) resel_n++;
   // ********
   // helpers
   // ********
   task automatic end_sim();
      if (error_cnt == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [18:0] exp,
      input logic [18:0] got);
      compares++;
      if (got !== exp) begin
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys_in);
   endtask : cyc
   // bounded wait for a state code; n returns the cycles it took
   task automatic wait_field(input logic [2:0] code, input int lim,
      output int cnt);
      cnt = 0;
      while (main_loop_state_field_out !== code) begin
         @(negedge clk_sys_in);
         cnt++;
         if (cnt > lim) begin
            $display("[FAIL] field exp %h got %h", code,
               main_loop_state_field_out);
            error_cnt++;
            end_sim();
         end
      end
   endtask : wait_field
   // ********
   // scenarios
   // ********
   task automatic t_reset();
      rst_in = 1'h1;
      cyc(20);
      chk("field", CODE_FREE_RUN, main_loop_state_field_out);
      chk("nom", NOM_FREQ_RESET, nom_freq_out);
      chk("osc", 1'h1, use_local_osc_out);
      chk("sec_zero", 1'h1, sec_zero_offset_out);
      rst_in = 1'h0;
      sec_ref_selected_in = 1'h1;
      sec_lock_in = 1'h1;
      cyc(6);
      chk("sec_lock", 1'h1, sec_locked_out);
      chk("sec_zero", 1'h0, sec_zero_offset_out);
      sec_lock_in = 1'h0;
      cyc(6);
      chk("sec_zero", 1'h1, sec_zero_offset_out);
   endtask : t_reset
   task automatic t_acq();
      sel_cmd = 1'h1;
      wait_field(CODE_PRELOCK, 10, n);
      chk("osc", 1'h0, use_local_osc_out);
      wait_field(CODE_FREE_RUN, 2 * ACQ, n);
      chk("acq_t", 1'h1, 19'(n >= ACQ - 4 && n <= ACQ + 4));
      chk("resel", 1'h1, 19'(resel_n == 1));
   endtask : t_acq
   task automatic t_lock();
      wait_field(CODE_PRELOCK, 10, n);
      lock_cmd = 1'h1;
      nom_freq_in = 16'h989a;
      wait_field(CODE_LOCKED, 4 * LQ, n);
      chk("lock_t", 1'h1, 19'(n >= LQ && n <= LQ + 8));
      chk("track", 1'h1, track_ref_out);
      chk("nom", 16'h989a, nom_freq_out);
   endtask : t_lock
   task automatic t_hold();
      loop_freq_in = 19'h2a5c3;
      loss_cmd = 1'h1;
      wait_field(CODE_LOST_PHASE, 10, n);
      bucket_serious_in = 1'h1;
      sel_cmd = 1'h0;
      wait_field(CODE_HOLDOVER, 10, n);
      chk("disq", 1'h1, 19'(disq_n == 1));
      chk("freeze", 1'h1, freeze_freq_out);
      loop_freq_in = 19'h15a3c;
      bucket_serious_in = 1'h0;
      loss_cmd = 1'h0;
      lock_cmd = 1'h0;
      cyc(6);
      chk("held", 19'h2a5c3, held_freq_out);
      chk("field", CODE_HOLDOVER, main_loop_state_field_out);
   endtask : t_hold
   task automatic t_pre2();
      revert_restore_in = 1'h1;
      wait_field(CODE_SECOND_PRELOCK, 10, n);
      revert_restore_in = 1'h0;
      sel_cmd = 1'h1;
      wait_field(CODE_HOLDOVER, 2 * ACQ, n);
      chk("pre2_t", 1'h1, 19'(n >= ACQ - 4 && n <= ACQ + 4));
      chk("resel", 1'h1, 19'(resel_n == 2));
   endtask : t_pre2
   task automatic t_alarm();
      standby_good_in = 1'h1;
      wait_field(CODE_SECOND_PRELOCK, 10, n);
      lock_cmd = 1'h1;
      wait_field(CODE_LOCKED, 4 * LQ, n);
      loss_cmd = 1'h1;
      wait_field(CODE_LOST_PHASE, 10, n);
      wait_field(CODE_SECOND_PRELOCK, 2 * ACQ, n);
      chk("lost_t", 1'h1, 19'(n >= ACQ - 4 && n <= ACQ + 4));
      chk("alarm", 1'h1, 19'(alarm_n == 1 && disq_n == 2));
   endtask : t_alarm
   task automatic t_force();
      force_mode_in = 1'h1;
      force_req_in = 1'h1;
      foreach (CODES[i]) begin
         force_state_in = CODES[i];
         wait_field(CODES[i], 10, n);
      end
      force_state_in = 3'h0;
      cyc(8);
      chk("refuse", CODE_LOST_PHASE, main_loop_state_field_out);
      force_state_in = 3'h3;
      cyc(8);
      chk("refuse", CODE_LOST_PHASE, main_loop_state_field_out);
      force_req_in = 1'h0;
      force_state_in = CODE_LOCKED;
      cyc(8);
      chk("no_req", CODE_LOST_PHASE, main_loop_state_field_out);
      force_mode_in = 1'h0;
      loss_cmd = 1'h0;
      rst_in = 1'h1;
      cyc(2);
      rst_in = 1'h0;
      wait_field(CODE_PRELOCK, 10, n);
   endtask : t_force
   initial begin
      {force_mode_in, force_req_in, force_state_in} = 5'h0;
      {bucket_serious_in, standby_good_in, revert_restore_in} = 3'h0;
      {sec_ref_selected_in, sec_lock_in, sel_cmd, lock_cmd} = 4'h0;
      loss_cmd = 1'h0;
      rst_in = 1'h1;
      nom_freq_in = 16'h9999;
      loop_freq_in = 19'h0;
      t_reset();
      t_acq();
      t_lock();
      t_hold();
      t_pre2();
      t_alarm();
      t_force();
      end_sim();
   end
endmodule : dosc_main_tb
bind dosc_main dosc_main_asserts #(.FREQ_W(FREQ_W)) u_chk (
   .clk_sys_in, .rst_in,
   .force_mode_in, .phase_loss_in, .bucket_serious_in, .ref_valid_in,
   .nom_freq_in, .main_loop_state_field_out, .track_ref_out,
   .use_local_osc_out, .freeze_freq_out, .held_freq_out, .nom_freq_out,
   .disqualify_out, .phase_alarm_out, .sec_locked_out, .sec_zero_offset_out);
